// file: shared/hlt_defines.svh
// Offsets, field positions, reset values and timing counts of the limit timer
`ifndef HLT_DEFINES_SVH
`define HLT_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define HLT_CTRL_OFS     8'h00
`define HLT_MODE_OFS     8'h04
`define HLT_PERIOD_OFS   8'h08
`define HLT_COUNT_OFS    8'h0c
`define HLT_IRQ_OFS      8'h10

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define HLT_CTRL_RUN_BIT 7
`define HLT_PRESCALE_SELECT_LSB     4
`define HLT_OUTPS_LSB    0
`define HLT_IRQ_FLAG_BIT 0
`define HLT_IRQ_EN_BIT   1

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define HLT_CTRL_RST     8'h00
`define HLT_MODE_RST     5'h00
`define HLT_PERIOD_RST   8'hff
`define HLT_RESTART_CLKS 2

`endif

// file: shared/hlt_pkg.sv
// Types shared by the hardware limit timer
`default_nettype none
package hlt_pkg;

  // Operating mode codes
  typedef enum logic [4:0] {
    HLT_SW_GATE    = 5'h00,
    HLT_GATE_HIGH  = 5'h01,
    HLT_GATE_LOW   = 5'h02,
    HLT_EDGE_ANY   = 5'h03,
    HLT_EDGE_RISE  = 5'h04,
    HLT_EDGE_FALL  = 5'h05,
    HLT_LVL_LOW    = 5'h06,
    HLT_LVL_HIGH   = 5'h07,
    HLT_OS_SW      = 5'h08,
    HLT_OS_RISE    = 5'h09,
    HLT_OS_FALL    = 5'h0a,
    HLT_OS_ANY     = 5'h0b,
    HLT_OSL_RISE   = 5'h0c,
    HLT_OSL_FALL   = 5'h0d
  } hlt_mode_e;

  // One-shot sequencing states
  typedef enum logic [2:0] {
    HLT_ST_IDLE  = 3'b001,
    HLT_ST_ARMED = 3'b010,
    HLT_ST_RUN   = 3'b100
  } hlt_state_e;

endpackage
`default_nettype wire

// file: design/hlt_timer.sv
// Hardware limit period timer with Wishbone register access
//
// Contract
// - Flag set after postscale ratio of matches
// - Interrupt output gated by enable bit
// - Flag set synchronised, held until cleared
// - Run bit and trigger pass two flops
// - Software gate counts while run set
// - Count wraps to zero after period match
// - Codes 1 and 2 gate by trigger level
// - Edge limit modes reset count on edge
// - Early reset restarts period, two-clock delay
// - Level modes hold reset at reset level
// - Level modes ignore trigger while run clear
// - Level reset two clocks after level reached
// - Resume two clocks after level released
// - Software one-shot clears run at match
// - Run pause mid-cycle resumes the count
// - Edge one-shot starts on selected edge
// - Halted edge one-shot needs fresh edge
// - First edge starts, later edges reset
// - Resume automatically two clocks after reset edge
// - Match clears run, edges ignored until set
// - Run clear resets prescaler, postscaler, state
//
// Added by the designer: the register offsets and register access over Wishbone.
`include "hlt_defines.svh"
`default_nettype none

module hlt_timer
  import hlt_pkg::*;
#(
  parameter int CW = 8
) (
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // Wishbone slave
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  input  wire logic          wb_we_i,
  input  wire logic [7:0]    wb_adr_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic [31:0]   wb_dat_i,
  output logic      [31:0]   wb_dat_o,
  output logic               wb_ack_o,
  // External reset trigger, from another source
  input  wire logic          ext_reset_signal_i,
  // Outputs to pulse unit and processor
  output logic               period_match_o,
  output logic               start_o,
  output logic               postscaled_match_o,
  output logic               timer_irq_o
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic            run;
  logic [2:0]      prescale_select;
  logic [3:0]      postscale_select;
  logic [4:0]      mode;
  logic [CW-1:0]   period_value;
  logic [CW-1:0]   count_value;
  logic            timer_irq_flag;
  logic            timer_irq_enable;
  logic            bus_req;
  logic            wr_ctrl;
  logic            wr_irq;
  logic            hw_clear_run;

  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_ctrl = bus_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == `HLT_CTRL_OFS);
  assign wr_irq  = bus_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == `HLT_IRQ_OFS);

  // Ack one cycle after request, dropped next cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  // Run bit: software write, hardware clear at one-shot end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run <= 1'(`HLT_CTRL_RST >> `HLT_CTRL_RUN_BIT);
    end else if (wr_ctrl) begin
      run <= wb_dat_i[`HLT_CTRL_RUN_BIT];
    end else if (hw_clear_run) begin
      run <= 1'b0;
    end
  end

  // Control fields, mode, period and interrupt enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prescale_select  <= 3'h0;
      postscale_select <= 4'h0;
      mode             <= `HLT_MODE_RST;
      period_value     <= CW'(`HLT_PERIOD_RST);
      timer_irq_enable <= 1'b0;
    end else if (bus_req && wb_we_i && wb_sel_i[0]) begin
      case (wb_adr_i)
        `HLT_CTRL_OFS: begin
          prescale_select  <= wb_dat_i[`HLT_PRESCALE_SELECT_LSB +: 3];
          postscale_select <= wb_dat_i[`HLT_OUTPS_LSB +: 4];
        end
        `HLT_MODE_OFS:   mode             <= wb_dat_i[4:0];
        `HLT_PERIOD_OFS: period_value     <= wb_dat_i[CW-1:0];
        `HLT_IRQ_OFS:    timer_irq_enable <= wb_dat_i[`HLT_IRQ_EN_BIT];
        default: ;
      endcase
    end
  end

  // Read data, unmapped reads zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0;
    end else if (bus_req) begin
      case (wb_adr_i)
        `HLT_CTRL_OFS:   wb_dat_o <= {24'h0, run, prescale_select, postscale_select};
        `HLT_MODE_OFS:   wb_dat_o <= {27'h0, mode};
        `HLT_PERIOD_OFS: wb_dat_o <= 32'(period_value);
        `HLT_COUNT_OFS:  wb_dat_o <= 32'(count_value);
        `HLT_IRQ_OFS:    wb_dat_o <= {30'h0, timer_irq_enable, timer_irq_flag};
        default:         wb_dat_o <= 32'h0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  logic       ers_s1;
  logic       ers_s2;
  logic       ers_d;
  logic       run_s1;
  logic       run_s2;

  // Two flops for trigger and run bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ers_s1 <= 1'b0;
      ers_s2 <= 1'b0;
      ers_d  <= 1'b0;
      run_s1 <= 1'b0;
      run_s2 <= 1'b0;
    end else begin
      ers_s1 <= ext_reset_signal_i;
      ers_s2 <= ers_s1;
      ers_d  <= ers_s2;
      run_s1 <= run && !hw_clear_run;
      run_s2 <= run_s1;
    end
  end

  logic rise;
  logic fall;
  assign rise = ers_s2 && !ers_d;
  assign fall = !ers_s2 && ers_d;

  // ----------------------------------------------------------------
  // Prescaler tick
  // ----------------------------------------------------------------
  logic [6:0] pre_cnt;
  logic       timer_tick;
  logic [6:0] pre_lim;

  assign pre_lim    = 7'((8'h1 << prescale_select) - 8'h1);
  assign timer_tick = (pre_cnt >= pre_lim);

  // Prescale counter, cleared while stopped
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_s2) begin
      pre_cnt <= 7'h0;
    end else if (timer_tick) begin
      pre_cnt <= 7'h0;
    end else begin
      pre_cnt <= pre_cnt + 7'h1;
    end
  end

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  logic edge_hit;
  logic lvl_reset;
  logic gate_ok;
  logic is_edge_lim;
  logic is_lvl;
  logic is_os_sw;
  logic is_os_edge;
  logic is_osl;

  always_comb begin
    edge_hit    = 1'b0;
    lvl_reset   = 1'b0;
    gate_ok     = 1'b1;
    is_edge_lim = 1'b0;
    is_lvl      = 1'b0;
    is_os_sw    = 1'b0;
    is_os_edge  = 1'b0;
    is_osl      = 1'b0;
    case (mode)
      HLT_SW_GATE:   gate_ok = 1'b1;
      HLT_GATE_HIGH: gate_ok = ers_s2;
      HLT_GATE_LOW:  gate_ok = !ers_s2;
      HLT_EDGE_ANY: begin
        is_edge_lim = 1'b1;
        edge_hit    = rise || fall;
      end
      HLT_EDGE_RISE: begin
        is_edge_lim = 1'b1;
        edge_hit    = rise;
      end
      HLT_EDGE_FALL: begin
        is_edge_lim = 1'b1;
        edge_hit    = fall;
      end
      HLT_LVL_LOW: begin
        is_lvl    = 1'b1;
        lvl_reset = !ers_s2;
      end
      HLT_LVL_HIGH: begin
        is_lvl    = 1'b1;
        lvl_reset = ers_s2;
      end
      HLT_OS_SW:     is_os_sw = 1'b1;
      HLT_OS_RISE: begin
        is_os_edge = 1'b1;
        edge_hit   = rise;
      end
      HLT_OS_FALL: begin
        is_os_edge = 1'b1;
        edge_hit   = fall;
      end
      HLT_OS_ANY: begin
        is_os_edge = 1'b1;
        edge_hit   = rise || fall;
      end
      HLT_OSL_RISE: begin
        is_osl   = 1'b1;
        edge_hit = rise;
      end
      HLT_OSL_FALL: begin
        is_osl   = 1'b1;
        edge_hit = fall;
      end
      default:       gate_ok = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Restart delay and one-shot state
  // ----------------------------------------------------------------
  logic [1:0] hold_cnt;
  logic       in_hold;
  hlt_state_e state;
  hlt_state_e next_state;
  logic       match;
  logic       os_mode;
  logic [1:0] lvl_age;

  assign in_hold = (hold_cnt != 2'h0);
  assign match   = (count_value == period_value);
  assign os_mode = is_os_sw || is_os_edge || is_osl;

  // Two-clock hold after a hardware reset
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_s2) begin
      hold_cnt <= 2'h0;
    end else if ((is_edge_lim || (is_osl && state == HLT_ST_RUN)) && edge_hit) begin
      hold_cnt <= 2'(`HLT_RESTART_CLKS);
    end else if (is_lvl && lvl_reset) begin
      hold_cnt <= 2'(`HLT_RESTART_CLKS);
    end else if (in_hold) begin
      hold_cnt <= hold_cnt - 2'h1;
    end
  end

  // Age of the reset level, saturating at the restart delay
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_s2 || !(is_lvl && lvl_reset)) begin
      lvl_age <= 2'h0;
    end else if (lvl_age != 2'(`HLT_RESTART_CLKS)) begin
      lvl_age <= lvl_age + 2'h1;
    end
  end

  // One-shot sequencing
  always_comb begin
    next_state = state;
    case (state)
      HLT_ST_IDLE:  next_state = is_os_sw ? HLT_ST_RUN : HLT_ST_ARMED;
      HLT_ST_ARMED: if (edge_hit) next_state = HLT_ST_RUN;
      HLT_ST_RUN:   next_state = HLT_ST_RUN;
      default:      next_state = HLT_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !run_s2 || hw_clear_run) begin
      state <= HLT_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // End of one-shot clears the run bit
  assign hw_clear_run = os_mode && run_s2 && state == HLT_ST_RUN && timer_tick && match;

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  logic counting;
  assign counting = run_s2 && gate_ok && !in_hold
                    && (!os_mode || state == HLT_ST_RUN);

  // Main count
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_value <= '0;
    end else if (!run_s2) begin
      count_value <= count_value;
    end else if ((is_edge_lim || (is_osl && state == HLT_ST_RUN)) && edge_hit) begin
      count_value <= '0;
    end else if (is_lvl && lvl_reset && lvl_age >= 2'(`HLT_RESTART_CLKS - 1)) begin
      count_value <= '0;
    end else if (counting && timer_tick) begin
      count_value <= match ? '0 : count_value + 1'b1;
    end
  end

  // Period match and start pulses to pulse unit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      period_match_o <= 1'b0;
      start_o        <= 1'b0;
    end else begin
      period_match_o <= counting && timer_tick && match;
      start_o        <= ((is_os_edge || is_osl) && state == HLT_ST_ARMED && edge_hit)
                        || (in_hold && hold_cnt == 2'h1);
    end
  end

  // ----------------------------------------------------------------
  // Postscaler and interrupt flag
  // ----------------------------------------------------------------
  logic [3:0] post_cnt;

  always_ff @(posedge clk_i) begin
    if (rst_i || !run_s2) begin
      post_cnt           <= 4'h0;
      postscaled_match_o <= 1'b0;
    end else begin
      postscaled_match_o <= 1'b0;
      if (period_match_o) begin
        if (post_cnt == postscale_select) begin
          post_cnt           <= 4'h0;
          postscaled_match_o <= 1'b1;
        end else begin
          post_cnt <= post_cnt + 4'h1;
        end
      end
    end
  end

  // Sticky flag, set wins over software clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_irq_flag <= 1'b0;
    end else if (postscaled_match_o) begin
      timer_irq_flag <= 1'b1;
    end else if (wr_irq && !wb_dat_i[`HLT_IRQ_FLAG_BIT]) begin
      timer_irq_flag <= 1'b0;
    end
  end

  assign timer_irq_o = timer_irq_flag && timer_irq_enable;

endmodule
`default_nettype wire

// file: dv/hlt_trig_src.sv
// Model of the on-chip trigger source feeding the timer
`default_nettype none
module hlt_trig_src (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Requested level and trigger line
  input  wire logic lvl_i,
  output logic      ers_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] gap;
  // Follow the request, but never two changes within six clocks
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ers_o <= 1'b0;
      gap   <= 4'h0;
    end else if (lvl_i != ers_o && gap >= 4'h5) begin
      ers_o <= lvl_i;
      gap   <= 4'h0;
    end else if (gap != 4'hf) begin
      gap <= gap + 4'h1;
    end
  end
endmodule
`default_nettype wire

// file: dv/hlt_timer_chk.sv
// Assertion checker watching the limit timer ports
`default_nettype none
module hlt_timer_chk #(
  parameter int CW = 8
) (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Timer events
  input wire logic        ext_reset_signal_i,
  input wire logic        period_match_o,
  input wire logic        start_o,
  input wire logic        postscaled_match_o,
  input wire logic        timer_irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic rd_ack;
  // Read answer in flight
  assign rd_ack = wb_ack_o && !wb_we_i;
  a_ack_after_req:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  a_ack_single:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_has_cause:
    assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("stray ack");
  a_unmapped_reads_zero:
    assert property (rd_ack && !(wb_adr_i inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10})
      |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
  a_mode_width:
    assert property (rd_ack && wb_adr_i == 8'h04 |-> wb_dat_o[31:5] == 27'h0)
      else $error("mode read too wide");
  a_irq_has_cause:
    assert property ($rose(timer_irq_o) |-> $past(postscaled_match_o) || postscaled_match_o
      || (wb_ack_o && wb_we_i && wb_adr_i == 8'h10)) else $error("irq without cause");
  a_irq_held:
    assert property (timer_irq_o && !(wb_cyc_i && wb_we_i) |=> timer_irq_o)
      else $error("irq dropped alone");
  a_post_follows_match:
    assert property (postscaled_match_o |-> period_match_o || $past(period_match_o))
      else $error("postscaled without match");
  // Main scenarios reached
  c_post: cover property (postscaled_match_o);
  c_start: cover property (start_o);
  c_irq: cover property ($rose(timer_irq_o));
endmodule
bind hlt_timer hlt_timer_chk #(.CW(CW)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_reset_signal_i(ext_reset_signal_i),
  .period_match_o(period_match_o), .start_o(start_o),
  .postscaled_match_o(postscaled_match_o), .timer_irq_o(timer_irq_o));
`default_nettype wire

// file: dv/tb_hw_limit_period_timer.sv
// Self-checking bench for the limit timer
`default_nettype none
module tb_hw_limit_period_timer;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, trig;
  logic        period_match_o, start_o, postscaled_match_o, timer_irq_o, fall;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, v;
  wire logic   ext_reset_signal_i;
  int          n_fail, checks_done, cyc_cnt, n;
  hlt_timer #(.CW(8)) u_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .ext_reset_signal_i, .period_match_o,
    .start_o, .postscaled_match_o, .timer_irq_o);
  hlt_trig_src u_src (.clk_i(clk_i), .rst_i(rst_i), .lvl_i(trig), .ers_o(ext_reset_signal_i));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // One classic bus cycle; read data lands in v
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    v = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    @(posedge clk_i);
  endtask
  // Cycles until the chosen event pulse
  task automatic wt(input int s, output int c);
    logic hit;
    c = 0;
    do begin
      @(posedge clk_i);
      c++;
      hit = (s == 0) ? period_match_o : (s == 1) ? postscaled_match_o :
            (s == 2) ? timer_irq_o : start_o;
    end while (hit !== 1'b1 && c < 2000);
    chk(32'(c < 2000), 32'h1);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // Hang guard
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      n_fail++;
      end_of_test();
    end
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, trig} = 4'h0;
    {rst_i, wb_adr_i, wb_sel_i, wb_dat_i} = {1'b1, 8'h00, 4'hf, 32'h0};
    {n_fail, checks_done, cyc_cnt} = '0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    bus(0, 8'h00, 0); chk(v, 32'h0);
    bus(0, 8'h08, 0); chk(v, 32'hff);
    bus(0, 8'h14, 0); chk(v, 32'h0);
    $display("test reset done");
    bus(1, 8'h08, 32'h5); bus(1, 8'h00, 32'h80);
    wt(0, n); wt(0, n); chk(n, 6);
    bus(0, 8'h0c, 0); chk(32'(v <= 32'h5), 32'h1);
    bus(1, 8'h00, 32'h90); wt(0, n); wt(0, n); chk(n, 12);
    bus(1, 8'h00, 32'h83); wt(1, n); wt(1, n); chk(n, 24);
    bus(1, 8'h10, 32'h2); wt(2, n); bus(1, 8'h00, 0);
    bus(0, 8'h10, 0); chk(v, 32'h3);
    bus(1, 8'h10, 32'h2); bus(0, 8'h10, 0); chk(v, 32'h2);
    bus(1, 8'h10, 0); bus(1, 8'h00, 32'h80); wt(1, n); repeat (3) @(posedge clk_i);
    chk({31'h0, timer_irq_o}, 32'h0); bus(0, 8'h10, 0); chk(v, 32'h1);
    $display("test counting done");
    bus(1, 8'h08, 32'h1c);
    for (int m = 3; m <= 5; m++) begin
      bus(1, 8'h00, 0); bus(1, 8'h04, m); trig <= (m == 5); repeat (8) @(posedge clk_i);
      bus(0, 8'h04, 0); chk(v, 32'(m));
      bus(1, 8'h00, 32'h80); wt(0, n); repeat (20) @(posedge clk_i);
      trig <= (m != 5); wt(3, n);
      bus(0, 8'h0c, 0); chk(32'(v < 32'h8), 32'h1);
    end
    $display("test edge limit done");
    for (int m = 1; m <= 7; m++) begin
      if (m inside {1, 2, 6, 7}) begin
        fall = (m == 2 || m == 7);
        bus(1, 8'h00, 0); bus(1, 8'h04, m); trig <= fall; repeat (8) @(posedge clk_i);
        bus(0, 8'h0c, 0); n = v;
        bus(1, 8'h00, 32'h80); repeat (20) @(posedge clk_i);
        bus(0, 8'h0c, 0); chk(v, (m > 5) ? 32'h0 : 32'(n));
        trig <= !fall; wt(0, n);
        trig <= fall; repeat (8) @(posedge clk_i); bus(0, 8'h0c, 0); n = v;
        repeat (4) @(posedge clk_i);
        bus(0, 8'h0c, 0); chk(v, (m > 5) ? 32'h0 : 32'(n));
      end
    end
    $display("test level done");
    bus(1, 8'h00, 0); bus(1, 8'h04, 8); bus(1, 8'h00, 32'h80); repeat (10) @(posedge clk_i);
    bus(1, 8'h00, 0); repeat (4) @(posedge clk_i); bus(0, 8'h0c, 0); n = v;
    repeat (9) @(posedge clk_i); bus(0, 8'h0c, 0); chk(v, 32'(n));
    bus(1, 8'h00, 32'h80); wt(0, n);
    repeat (3) @(posedge clk_i);
    bus(0, 8'h00, 0); chk(v, 32'h0);
    for (int m = 9; m <= 13; m++) begin
      fall = (m == 10 || m == 13);
      bus(1, 8'h00, 0); trig <= fall; repeat (8) @(posedge clk_i);
      bus(1, 8'h04, m); bus(1, 8'h00, 32'h80); repeat (20) @(posedge clk_i);
      bus(0, 8'h0c, 0); chk(v, 32'h0);
      trig <= !fall; wt(0, n); repeat (3) @(posedge clk_i);
      bus(0, 8'h00, 0); chk(v, 32'h0);
    end
    $display("test one-shot done");
    end_of_test();
  end
endmodule
`default_nettype wire
